// file: design/alu_defines.vh
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_RESULT 12'h00C
`define OFS_FILE_BASE 12'h200
`define OFS_FILE_LAST 12'h3FC

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DEST_BIT 3
`define CMD_BIT_LSB 4
`define CMD_BIT_MSB 6
`define CMD_ADDR_LSB 7
`define CMD_ADDR_MSB 13
`define CMD_IMM_LSB 14
`define CMD_IMM_MSB 21

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_NOP 3'h0
`define OP_ADD_IMM 3'h1
`define OP_ADD_REG 3'h2
`define OP_AND_IMM 3'h3
`define OP_AND_REG 3'h4
`define OP_SET_BIT 3'h5
`define OP_CLR_BIT 3'h6
`define OP_TEST_SKIP 3'h7

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_SKIP 3
`define ACC_RESET 8'h00
`define STATUS_RESET 3'h0

`endif

// file: design/alu8.v
`default_nettype none

// ----------------------------------------------------------------
// Eight-bit add / and unit with carry, nibble overflow and zero
// ----------------------------------------------------------------
module alu8
(
	input wire [7:0] a,
	input wire [7:0] b,
	input wire do_and,
	output wire [7:0] result,
	output wire carry,
	output wire nibble_overflow_flag,
	output wire zero
);

	wire [8:0] sum;
	wire [4:0] low_sum;

	// Full and low-nibble sums; nibble carry comes from bit 3 into bit 4
	assign sum = {1'b0, a} + {1'b0, b};
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	assign result = do_and ? (a & b) : sum[7:0];
	assign carry = sum[8];
	assign nibble_overflow_flag = low_sum[4];
	// Zero flag follows the 8-bit result only
	assign zero = (result == 8'h00);

endmodule // alu8

`default_nettype wire

// file: design/bit_modify.v
`default_nettype none

// ----------------------------------------------------------------
// Single-bit set, clear and test on one byte
// ----------------------------------------------------------------
module bit_modify
(
	input wire [7:0] data_in,
	input wire [2:0] bit_sel,
	input wire set_value,
	output wire [7:0] data_out,
	output wire bit_value
);

	wire [7:0] mask;

	// One-hot mask of the selected position
	assign mask = 8'h01 << bit_sel;
	assign data_out = set_value ? (data_in | mask) : (data_in & ~mask);
	assign bit_value = |(data_in & mask);

endmodule // bit_modify

`default_nettype wire

// file: design/cpu_logic_add_bit_ops.v
`include "alu_defines.vh"
`default_nettype none

module cpu_logic_add_bit_ops
#(
	parameter ADDR_W = 12,
	parameter FILE_DEPTH = 128
)
(
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg skip_req,
	output reg exec_done
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [7:0] acc_r;
	reg [7:0] acc_nxt;
	reg [2:0] flags_r;
	reg [2:0] flags_nxt;
	reg skip_r;
	reg skip_nxt;
	reg [7:0] result_r;
	reg [7:0] result_nxt;
	reg file_we;
	reg [7:0] file_wdata;
	reg [7:0] file_mem [0:FILE_DEPTH-1];

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire access;
	wire wr_access;
	wire rd_access;
	wire hit_cmd;
	wire hit_acc;
	wire hit_status;
	wire hit_result;
	wire hit_file;
	wire mapped;
	wire [6:0] bus_file_addr;

	// Access phase; the slave answers at once, so every access is one wait-free cycle
	assign access = psel & penable;
	assign wr_access = access & pwrite;
	assign rd_access = access & ~pwrite;
	assign pready = 1'b1;
	assign hit_cmd = (paddr == `OFS_CMD);
	assign hit_acc = (paddr == `OFS_ACC);
	assign hit_status = (paddr == `OFS_STATUS);
	assign hit_result = (paddr == `OFS_RESULT);
	assign hit_file = (paddr >= `OFS_FILE_BASE) && (paddr <= `OFS_FILE_LAST) && (paddr[1:0] == 2'b00);
	assign mapped = hit_cmd | hit_acc | hit_status | hit_result | hit_file;
	// Unmapped or misaligned addresses answer with an error and change nothing
	assign pslverr = access & ~mapped;
	assign bus_file_addr = paddr[8:2];

	// ----------------------------------------------------------------
	// Command fields
	// ----------------------------------------------------------------
	wire [2:0] op;
	wire dest_reg;
	wire [2:0] bit_idx;
	wire [6:0] file_addr;
	wire [7:0] imm;
	wire cmd_go;
	wire [7:0] file_rdata;

	assign op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
	assign dest_reg = pwdata[`CMD_DEST_BIT];
	assign bit_idx = pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
	assign file_addr = pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
	assign imm = pwdata[`CMD_IMM_MSB:`CMD_IMM_LSB];
	// A command needs its low byte lanes; a partial write would leave the operands undefined
	assign cmd_go = wr_access & hit_cmd & pstrb[0] & pstrb[1] & pstrb[2];
	assign file_rdata = file_mem[file_addr];

	// ----------------------------------------------------------------
	// Datapath units
	// ----------------------------------------------------------------
	wire use_reg;
	wire do_and;
	wire [7:0] alu_b;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;
	wire [7:0] bit_res;
	wire bit_val;

	// Register forms take the file operand, immediate forms the literal
	assign use_reg = (op == `OP_ADD_REG) || (op == `OP_AND_REG);
	assign do_and = (op == `OP_AND_IMM) || (op == `OP_AND_REG);
	assign alu_b = use_reg ? file_rdata : imm;

	alu8 u_alu
	(
		.a(acc_r),
		.b(alu_b),
		.do_and(do_and),
		.result(alu_res),
		.carry(alu_c),
		.nibble_overflow_flag(alu_dc),
		.zero(alu_z)
	);

	bit_modify u_bit
	(
		.data_in(file_rdata),
		.bit_sel(bit_idx),
		.set_value(op == `OP_SET_BIT),
		.data_out(bit_res),
		.bit_value(bit_val)
	);

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	// One command per bus write; a pending skip turns the next command into a no-operation
	always @*
	begin
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		skip_nxt = skip_r;
		result_nxt = result_r;
		file_we = 1'b0;
		file_wdata = 8'h00;
		if (cmd_go)
		begin
			if (skip_r)
			begin
				// Discarded instruction: second cycle of the skip, only clears the skip and still raises exec_done
				skip_nxt = 1'b0;
			end
			else
			begin
				case (op)
					`OP_ADD_IMM:
					begin
						acc_nxt = alu_res;
						result_nxt = alu_res;
						flags_nxt[`ST_CARRY] = alu_c;
						flags_nxt[`ST_NIBBLE] = alu_dc;
						flags_nxt[`ST_ZERO] = alu_z;
					end
					`OP_ADD_REG:
					begin
						result_nxt = alu_res;
						flags_nxt[`ST_CARRY] = alu_c;
						flags_nxt[`ST_NIBBLE] = alu_dc;
						flags_nxt[`ST_ZERO] = alu_z;
						if (dest_reg)
						begin
							file_we = 1'b1;
							file_wdata = alu_res;
						end
						else
						begin
							acc_nxt = alu_res;
						end
					end
					`OP_AND_IMM:
					begin
						acc_nxt = alu_res;
						result_nxt = alu_res;
						flags_nxt[`ST_ZERO] = alu_z;
					end
					`OP_AND_REG:
					begin
						result_nxt = alu_res;
						flags_nxt[`ST_ZERO] = alu_z;
						if (dest_reg)
						begin
							file_we = 1'b1;
							file_wdata = alu_res;
						end
						else
						begin
							acc_nxt = alu_res;
						end
					end
					`OP_SET_BIT, `OP_CLR_BIT:
					begin
						// Flags stay untouched for bit writes
						file_we = 1'b1;
						file_wdata = bit_res;
						result_nxt = bit_res;
					end
					`OP_TEST_SKIP:
					begin
						skip_nxt = ~bit_val;
					end
					default:
					begin
						acc_nxt = acc_r;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Software writes to accumulator and status come last and would win over a command, but both share one address path so they never coincide
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			acc_r <= `ACC_RESET;
			flags_r <= `STATUS_RESET;
			skip_r <= 1'b0;
			result_r <= 8'h00;
			skip_req <= 1'b0;
			exec_done <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			flags_r <= flags_nxt;
			skip_r <= skip_nxt;
			result_r <= result_nxt;
			// Tells the fetch unit that the following instruction is to be dropped
			skip_req <= cmd_go & ~skip_r & (op == `OP_TEST_SKIP) & ~bit_val;
			exec_done <= cmd_go;
			if (wr_access & hit_acc & pstrb[0])
			begin
				acc_r <= pwdata[7:0];
			end
			if (wr_access & hit_status & pstrb[0])
			begin
				flags_r <= pwdata[2:0];
			end
		end
	end

	// File space: no reset, contents are data, not control
	always @(posedge mclk)
	begin
		if (file_we)
		begin
			file_mem[file_addr] <= file_wdata;
		end
		else if (wr_access & hit_file & pstrb[0])
		begin
			file_mem[bus_file_addr] <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Registered in the setup cycle so data is stable through the access phase
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h00000000;
		end
		else if (psel & ~penable & ~pwrite)
		begin
			if (hit_acc)
			begin
				prdata <= {24'h000000, acc_r};
			end
			else if (hit_status)
			begin
				prdata <= {28'h0000000, skip_r, flags_r};
			end
			else if (hit_result)
			begin
				prdata <= {24'h000000, result_r};
			end
			else if (hit_file)
			begin
				prdata <= {24'h000000, file_mem[bus_file_addr]};
			end
			else
			begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule // cpu_logic_add_bit_ops

`default_nettype wire

// file: tb/cpu_logic_add_bit_ops_assertions.sv
`include "alu_defines.vh"
`default_nettype none
// ----------------
// Bus answer and completion strobes
// ----------------
module alu_bus_checker
#(
	parameter ADDR_W = 12
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic skip_req,
	input wire logic exec_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// A command only counts with its low three lanes written
	wire cw = psel & penable & pwrite & (paddr == `OFS_CMD) & (&pstrb[2:0]);
	wire rd = psel & penable & ~pwrite;
	a_done_cmd: assert property (cw |=> exec_done) else $error("no done after command");
	a_done_cause: assert property (exec_done |-> $past(cw)) else $error("done without command");
	a_skip_cause: assert property (skip_req |-> exec_done && $past(pwdata[2:0]) == `OP_TEST_SKIP)
		else $error("skip without test command");
	a_skip_once: assert property (skip_req |=> !skip_req [*2]) else $error("skip held too long");
	a_ready_high: assert property (pready) else $error("wait state inserted");
	a_err_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("misaligned access accepted");
	a_err_none: assert property (psel && penable && paddr == `OFS_ACC |-> !pslverr) else $error("error on mapped");
	a_cmd_reads0: assert property (rd && paddr == `OFS_CMD |-> prdata == 32'h0) else $error("command reads data");
	a_read_width: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule // alu_bus_checker
`default_nettype wire

// file: tb/decoder_model.sv
`default_nettype none
// ----------------
// Decoder side: issues commands and register traffic
// ----------------
module decoder_model
(
	input wire logic mclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h0,
	output logic [3:0] pstrb = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// One transfer; an idle cycle first keeps each strobe to one change per step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines flip so stale values cannot pass
		paddr <= ~a;
		pwdata <= ~d;
		// A slave that never answers ends the run as a mismatch
		if (pready !== 1'b1)
		begin
			cpu_logic_add_bit_ops_tb_top.failures++;
			cpu_logic_add_bit_ops_tb_top.give_verdict();
		end
	endtask
endmodule // decoder_model
`default_nettype wire

// file: tb/cpu_logic_add_bit_ops_tb_top.sv
`include "alu_defines.vh"
`default_nettype none
// ----------------
// Random command stream against a reference model
// ----------------
module cpu_logic_add_bit_ops_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, skip_req, exec_done, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, r;
	logic [3:0] pstrb;
	logic [7:0] acc;
	logic [7:0] rslt;
	logic [7:0] mem [128];
	logic [3:0] st;
	integer failures = 0;
	integer check_count = 0;
	integer seed = 32'h30a7;
	always #25 mclk = ~mclk;
	cpu_logic_add_bit_ops DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.skip_req(skip_req), .exec_done(exec_done));
	decoder_model bus (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		check_count++;
		if (x !== y)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
		bus.xfer(1'b0, a, 32'h0, 4'h0, q, e);
		chk(n, x, q);
		chk("slverr", 32'h0, {31'h0, e});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus.xfer(1'b1, a, d, 4'hF, q, e);
	endtask
	// Model first, then the design; a pending skip swallows the command whole
	task automatic cmd(input logic [2:0] op, input logic d, input logic [2:0] b, input logic [6:0] f,
		input logic [7:0] k);
		logic [7:0] x;
		logic [7:0] res;
		logic [8:0] s;
		x = (op == `OP_ADD_REG || op == `OP_AND_REG) ? mem[f] : k;
		s = 9'(acc) + 9'(x);
		res = op < 3'h3 ? s[7:0] : acc & x;
		if (st[3])
			st[3] = 1'b0;
		else if (op != 3'h0 && op < 3'h5)
		begin
			st[2] = res == 8'h0;
			if (op < 3'h3)
				st[1:0] = {5'(acc[3:0]) + 5'(x[3:0]) > 5'hF, s[8]};
			rslt = res;
			if (op[0] || !d)
				acc = res;
			else
				mem[f] = res;
		end
		else if (op == `OP_SET_BIT || op == `OP_CLR_BIT)
		begin
			mem[f][b] = op == `OP_SET_BIT;
			rslt = mem[f];
		end
		else if (op == `OP_TEST_SKIP)
			st[3] = !mem[f][b];
		wr(`OFS_CMD, {10'h0, k, f, b, d, op});
		#1;
		chk("skip", {31'h0, st[3]}, {31'h0, skip_req});
		chk("done", 32'h1, {31'h0, exec_done});
		rd("acc", `OFS_ACC, {24'h0, acc});
		rd("status", `OFS_STATUS, {28'h0, st});
		rd("file", `OFS_FILE_BASE + {1'b0, f, 2'h0}, {24'h0, mem[f]});
		rd("result", `OFS_RESULT, {24'h0, rslt});
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		acc = 8'h0;
		st = 4'h0;
		rslt = 8'h0;
		rd("acc", `OFS_ACC, 32'h0);
		rd("status", `OFS_STATUS, 32'h0);
		// Files have no reset value, so load every one first
		for (int i = 0; i < 128; i++)
		begin
			mem[i] = 8'($random(seed));
			wr(`OFS_FILE_BASE + 12'(i * 4), {24'h0, mem[i]});
		end
		// Both nibbles overflow at once: carry, nibble carry and zero rise
		wr(`OFS_ACC, 32'hFF);
		acc = 8'hFF;
		cmd(`OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01);
		// AND must leave carry and nibble carry as software set them
		wr(`OFS_STATUS, 32'h7);
		st = 4'h7;
		wr(`OFS_ACC, 32'hF0);
		acc = 8'hF0;
		cmd(`OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h30);
		cmd(`OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h00);
		// Partial strobes leave a command unexecuted
		bus.xfer(1'b1, `OFS_CMD, 32'h4401, 4'h8, q, e);
		#1;
		chk("done", 32'h0, {31'h0, exec_done});
		rd("acc", `OFS_ACC, {24'h0, acc});
		// Result is read-only and the command word reads as zero
		wr(`OFS_RESULT, 32'hA5);
		rd("result", `OFS_RESULT, {24'h0, rslt});
		rd("cmd", `OFS_CMD, 32'h0);
		// Unmapped and misaligned places answer with an error and read zero
		for (int i = 0; i < 2; i++)
		begin
			bus.xfer(1'b0, i ? 12'h005 : 12'h010, 32'h0, 4'h0, q, e);
			chk("err", 32'h1, {31'h0, e});
			chk("unmapped", 32'h0, q);
		end
		// Every code twice in order, then a random mix
		for (int i = 0; i < 400; i++)
		begin
			r = $random(seed);
			cmd(i < 16 ? 3'(i) : r[31:29], r[0], r[3:1], r[10:4], r[18:11]);
		end
		// Reset in mid-run with a skip pending: state clears and the next command is not swallowed
		cmd(`OP_NOP, 1'b0, 3'h0, 7'h00, 8'h00);
		cmd(`OP_CLR_BIT, 1'b0, 3'h0, 7'h00, 8'h00);
		cmd(`OP_TEST_SKIP, 1'b0, 3'h0, 7'h00, 8'h00);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		acc = 8'h0;
		st = 4'h0;
		rslt = 8'h0;
		rd("acc", `OFS_ACC, 32'h0);
		rd("status", `OFS_STATUS, 32'h0);
		rd("result", `OFS_RESULT, 32'h0);
		cmd(`OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h05);
		give_verdict();
	end
endmodule // cpu_logic_add_bit_ops_tb_top
bind cpu_logic_add_bit_ops alu_bus_checker #(.ADDR_W(ADDR_W)) chk_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .skip_req(skip_req), .exec_done(exec_done));
`default_nettype wire
